// *** design/iec_top.sv ***
// Interval event counter with register port, pin gating and interrupt.
`timescale 1ns/100ps
`default_nettype none

module iec_top #(
  parameter int unsigned TICKS_A = iec_pkg::TICKS_A,
  parameter int unsigned TICKS_B = iec_pkg::TICKS_B,
  parameter int unsigned TICKS_C = iec_pkg::TICKS_C,
  parameter int unsigned TICKS_D = iec_pkg::TICKS_D
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output var  logic [7:0]  rdata_q,
  input  wire logic        event_input_pin,
  output var  logic        counter_output_pin_q,
  output var  logic        counter_output_pin_oe_n_q,
  output var  logic        shift_tick_q,
  output var  logic        irq_q
);

  localparam int unsigned PW = iec_pkg::PRESC_W;

  //////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event pin synchroniser and edge detection.

  logic ev_s1_q;
  logic ev_s2_q;
  logic ev_s3_q;
  wire  ev_rise;
  wire  ev_fall;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else begin
      ev_s1_q <= event_input_pin;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  assign ev_rise = ev_s2_q & ~ev_s3_q;
  assign ev_fall = ~ev_s2_q & ev_s3_q;

  //////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire sel_mode;
  wire sel_oe;
  wire sel_limit;
  wire sel_count;
  wire sel_status;
  wire sel_clear;
  wire sel_enable;
  wire sel_pin;

  assign sel_mode   = (addr == iec_pkg::OFF_MODE);
  assign sel_oe     = (addr == iec_pkg::OFF_OE_FLAG);
  assign sel_limit  = (addr == iec_pkg::OFF_LIMIT);
  assign sel_count  = (addr == iec_pkg::OFF_COUNT);
  assign sel_status = (addr == iec_pkg::OFF_STATUS);
  assign sel_clear  = (addr == iec_pkg::OFF_CLEAR);
  assign sel_enable = (addr == iec_pkg::OFF_ENABLE);
  assign sel_pin    = (addr == iec_pkg::OFF_PIN);

  wire wr_mode;
  wire wr_oe;
  wire wr_limit;
  wire wr_clear;
  wire wr_enable;
  wire start;

  assign wr_mode   = wr_en & sel_mode;
  assign wr_oe     = wr_en & sel_oe;
  assign wr_limit  = wr_en & sel_limit;
  assign wr_clear  = wr_en & sel_clear;
  assign wr_enable = wr_en & sel_enable;
  // A start clears the count, the prescaler and the toggle.
  assign start     = wr_mode & wdata[iec_pkg::MODE_START_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic       oe_flag_q;
  logic [7:0] limit_q;
  logic       irq_en_q;

  // The start bit is held for exactly the cycle after the write and then
  // drops by itself, since counting restarts in that same cycle.
  assign mode_d = wr_mode
                ? (wdata & iec_pkg::MODE_WMASK)
                : (mode_q & ~(8'h01 << iec_pkg::MODE_START_BIT));

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q    <= iec_pkg::MODE_RESET;
      oe_flag_q <= 1'b0;
      limit_q   <= 8'hff;
      irq_en_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (wr_oe) begin
        oe_flag_q <= wdata[0];
      end
      if (wr_limit) begin
        limit_q <= wdata;
      end
      if (wr_enable) begin
        irq_en_q <= wdata[iec_pkg::STAT_MATCH_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Count pulse generation.

  wire       run;
  wire [2:0] src_sel;
  wire       src_internal;

  assign run     = mode_q[iec_pkg::MODE_RUN_BIT];
  assign src_sel = mode_q[iec_pkg::MODE_SEL_HI:iec_pkg::MODE_SEL_LO];
  assign src_internal = src_sel[2];

  wire [PW-1:0] presc_top;

  assign presc_top =
      (src_sel == iec_pkg::SEL_DIV_A) ? PW'(TICKS_A - 1) :
      (src_sel == iec_pkg::SEL_DIV_B) ? PW'(TICKS_B - 1) :
      (src_sel == iec_pkg::SEL_DIV_C) ? PW'(TICKS_C - 1) :
                                        PW'(TICKS_D - 1);

  logic [PW-1:0] presc_q;
  logic [PW-1:0] presc_d;
  wire           presc_hit;

  assign presc_hit = (presc_q == presc_top);

  // The divider idles at zero while stopped so a new run starts with a
  // full first period.
  assign presc_d = (start | presc_hit | ~run | ~src_internal)
                 ? '0
                 : presc_q + PW'(1);

  wire ext_pulse;
  wire raw_pulse;
  wire count_pulse;

  assign ext_pulse =
      ((src_sel == iec_pkg::SEL_EV_RISE) & ev_rise) |
      ((src_sel == iec_pkg::SEL_EV_FALL) & ev_fall);

  assign raw_pulse = src_internal ? presc_hit : ext_pulse;

  // Forbidden codes leave raw_pulse low and the count frozen.
  assign count_pulse = run & raw_pulse & ~start;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Count register, comparator and toggle flip-flop.

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       toggle_q;
  logic       toggle_d;
  wire        match;

  // The compare happens on the pulse that would pass the limit, so the
  // count walks 0..limit and a match arrives every limit+1 pulses.
  assign match = count_pulse & (count_q == limit_q);

  assign count_d = start       ? 8'h00 :
                   match       ? 8'h00 :
                   count_pulse ? count_q + 8'h01 :
                                 count_q;

  assign toggle_d = start ? 1'b0 :
                    match ? ~toggle_q :
                            toggle_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q  <= 8'h00;
      toggle_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      toggle_q <= toggle_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Match interrupt flag.

  logic match_flag_q;
  wire  match_flag_d;
  wire  flag_clr;

  assign flag_clr = wr_clear & wdata[iec_pkg::STAT_MATCH_BIT];

  // A match in the same cycle as a clear keeps the flag set.
  assign match_flag_d = match | (match_flag_q & ~flag_clr);

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      match_flag_q <= 1'b0;
    end else begin
      match_flag_q <= match_flag_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe and zero otherwise.

  wire [7:0] rd_mux;

  assign rd_mux =
      sel_mode   ? mode_q :
      sel_limit  ? limit_q :
      sel_count  ? count_q :
      sel_status ? {7'h00, match_flag_q} :
      sel_enable ? {7'h00, irq_en_q} :
      sel_pin    ? {7'h00, ev_s2_q} :
                   8'h00;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_en ? rd_mux : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // The pin is loaded from toggle_d, so it changes in the same cycle as the toggle; the enable is
  // active low so a disabled pin floats.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      counter_output_pin_q      <= 1'b0;
      counter_output_pin_oe_n_q <= 1'b1;
      shift_tick_q              <= 1'b0;
      irq_q                     <= 1'b0;
    end else begin
      counter_output_pin_q      <= toggle_d;
      counter_output_pin_oe_n_q <= ~(wr_oe ? wdata[0] : oe_flag_q);
      shift_tick_q              <= count_pulse;
      irq_q                     <= match_flag_d & irq_en_q;
    end
  end

endmodule // iec_top

`default_nettype wire

// *** include/iec_pkg.sv ***
// Constants, register map and field layout of the interval event counter.
// Function
// - Mode register bit 3 self-clearing start bit
// - Reset clears the whole mode register
// - Write-only flag gates toggle onto output pin
// - Every match inverts the toggle flip-flop
// - Writing start bit resets toggle flip-flop
// - Reset clears output enable and toggle
// - Pin, modulo, count, flag always accessible
// - Bit 2 low stops count pulses
// - Bit 2 high feeds selected pulse source
// - Select codes 4 to 7 map to four fixed resolutions
// - Count equal to modulo: match, clear count
// - Match interval is (modulo plus one) pulses
// - Event input divided by count on pin
// - Count timing offered as serial shift clock
`default_nettype none

package iec_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [11:0] OFF_MODE    = 12'hfa0;
  localparam logic [11:0] OFF_OE_FLAG = 12'hfa2;
  localparam logic [11:0] OFF_LIMIT   = 12'hfa4;
  localparam logic [11:0] OFF_COUNT   = 12'hfa6;
  localparam logic [11:0] OFF_STATUS  = 12'hfa8;
  localparam logic [11:0] OFF_CLEAR   = 12'hfa9;
  localparam logic [11:0] OFF_ENABLE  = 12'hfaa;
  localparam logic [11:0] OFF_PIN     = 12'hfac;

  // Mode register fields.
  localparam int unsigned MODE_RUN_BIT   = 2;
  localparam int unsigned MODE_START_BIT = 3;
  localparam int unsigned MODE_SEL_LO    = 4;
  localparam int unsigned MODE_SEL_HI    = 6;
  localparam logic [7:0]  MODE_WMASK     = 8'h7c;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam int unsigned STAT_MATCH_BIT = 0;

  // Count pulse source codes.
  localparam logic [2:0] SEL_EV_RISE = 3'h0;
  localparam logic [2:0] SEL_EV_FALL = 3'h1;
  localparam logic [2:0] SEL_DIV_A   = 3'h4;
  localparam logic [2:0] SEL_DIV_B   = 3'h5;
  localparam logic [2:0] SEL_DIV_C   = 3'h6;
  localparam logic [2:0] SEL_DIV_D   = 3'h7;

  // Count pulse periods in nanoseconds and the ref_clk period.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RES_A_NS      = 171000;
  localparam int unsigned RES_B_NS      = 42700;
  localparam int unsigned RES_C_NS      = 10700;
  localparam int unsigned RES_D_NS      = 2670;
  localparam int unsigned TICKS_A = RES_A_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_B = RES_B_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_C = RES_C_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_D = RES_D_NS / CLK_PERIOD_NS;

  localparam int unsigned PRESC_W = 16;

endpackage : iec_pkg

`default_nettype wire

// *** tb/iec_properties.sv ***
// Port-level concurrent checks for the interval event counter.
`timescale 1ns/100ps
`default_nettype none

module iec_properties (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata_q,
  input wire logic        counter_output_pin_q,
  input wire logic        counter_output_pin_oe_n_q,
  input wire logic        shift_tick_q,
  input wire logic        irq_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic wm = wr_en && addr == iec_pkg::OFF_MODE;
  wire logic wo = wr_en && addr == iec_pkg::OFF_OE_FLAG;
  wire logic we = wr_en && addr == iec_pkg::OFF_ENABLE;
  sequence start_wr; wm && wdata[3]; endsequence
  sequence stop_wr; wm && !wdata[2]; endsequence
  sequence quiet_8; !shift_tick_q [*8]; endsequence
  a_read_idle_zero: assert property (
    !$past(rd_en) |-> rdata_q == 8'h00)
    else $error("read data outside its cycle");
  a_flag_reads_zero: assert property (
    rd_en && addr == iec_pkg::OFF_OE_FLAG |=> rdata_q == 8'h00)
    else $error("write-only flag readable");
  a_start_clears_toggle: assert property (
    start_wr |=> !counter_output_pin_q)
    else $error("start left toggle set");
  a_oe_follows_write: assert property (
    wo |=> counter_output_pin_oe_n_q == !$past(wdata[0]))
    else $error("output enable not taken");
  a_oe_holds_steady: assert property (
    !wo |=> $stable(counter_output_pin_oe_n_q))
    else $error("output enable moved");
  a_toggle_needs_match: assert property (
    !$stable(counter_output_pin_q) |->
      shift_tick_q || $past(wm && wdata[3]))
    else $error("toggle moved without a pulse");
  a_irq_rise_cause: assert property (
    $rose(irq_q) |-> shift_tick_q || $past(we) || $past(we, 2))
    else $error("interrupt rose without cause");
  a_stop_no_tick: assert property (
    stop_wr |=> ##1 quiet_8)
    else $error("pulses while stopped");
endmodule // iec_properties

bind iec_top iec_properties chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata_q(rdata_q), .counter_output_pin_q(counter_output_pin_q),
  .counter_output_pin_oe_n_q(counter_output_pin_oe_n_q),
  .shift_tick_q(shift_tick_q), .irq_q(irq_q));

`default_nettype wire

// *** tb/iec_event_src.sv ***
// Outside event source that drives the event input pin.
`timescale 1ns/100ps
`default_nettype none

module iec_event_src (
  input  wire logic ref_clk,
  output var  logic event_input_pin
);
  initial event_input_pin = 1'b0;
  // Levels last five cycles so the pin synchroniser sees every edge.
  task automatic pulses(input int n);
    repeat (n) begin
      event_input_pin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      event_input_pin <= 1'b0;
      repeat (5) @(posedge ref_clk);
    end
  endtask
endmodule // iec_event_src

`default_nettype wire

// *** tb/interval_event_counter_bench.sv ***
// Self-checking bench for the interval event counter.
`timescale 1ns/100ps
`default_nettype none

module interval_event_counter_bench;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [11:0] addr    = 12'h000;
  logic [7:0]  wdata   = 8'h00;
  wire logic [7:0] rdata_q;
  wire logic   ev, pin, oe_n, tick, irq;
  int          n_fail = 0;
  int          n_checks = 0;
  localparam int TK [4] = '{4, 3, iec_pkg::TICKS_C, iec_pkg::TICKS_D};
  int          n_tick = 0;

  // Counted on the falling edge, where the registered tick has settled.
  always @(negedge ref_clk) begin
    if (tick === 1'b1) begin
      n_tick++;
    end
  end

  initial forever #4 ref_clk = ~ref_clk;

  // Only the two slowest dividers are shortened to keep the run brief; the
  // two fastest run at their real lengths.
  iec_top #(.TICKS_A(4), .TICKS_B(3)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .event_input_pin(ev), .counter_output_pin_q(pin),
    .counter_output_pin_oe_n_q(oe_n), .shift_tick_q(tick), .irq_q(irq));
  iec_event_src P (.ref_clk(ref_clk), .event_input_pin(ev));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int e);
    n_checks++;
    if (g != e) begin
      n_fail++;
      $display("[FAIL] %0t count %0d expected %0d", $time, g, e);
    end
  endtask
  // Every access is followed by an idle cycle, so no strobe is driven twice.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rdata_q, e);
    @(posedge ref_clk);
  endtask
  task automatic wait_pin(output int c);
    logic p;
    p = pin;
    c = 0;
    while (pin === p && c < 6000) begin
      @(posedge ref_clk);
      #1 c++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(iec_pkg::OFF_MODE, 8'h00);
    chk({6'h00, oe_n, pin}, 8'h02);
    rdc(iec_pkg::OFF_OE_FLAG, 8'h00);
    rdc(iec_pkg::OFF_LIMIT, 8'hff);
    rdc(12'h123, 8'h00);
  endtask
  task automatic t_interval();
    int c;
    wr(iec_pkg::OFF_LIMIT, 8'h03);
    wr(iec_pkg::OFF_OE_FLAG, 8'h01);
    chk({7'h00, oe_n}, 8'h00);
    for (int s = 4; s < 8; s++) begin
      wr(iec_pkg::OFF_MODE, {1'b0, s[2:0], 4'hc});
      chk({7'h00, pin}, 8'h00);
      wait_pin(c);
      wait_pin(c);
      chk_cnt(c, 4 * TK[s-4]);
    end
    rdc(iec_pkg::OFF_MODE, 8'h74);
  endtask
  task automatic t_irq_stop();
    int c;
    wr(iec_pkg::OFF_ENABLE, 8'h01);
    wait_pin(c);
    chk({7'h00, irq}, 8'h01);
    rdc(iec_pkg::OFF_STATUS, 8'h01);
    wr(iec_pkg::OFF_MODE, 8'h83);
    rdc(iec_pkg::OFF_MODE, 8'h00);
    wr(iec_pkg::OFF_CLEAR, 8'h01);
    rdc(iec_pkg::OFF_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    repeat (20) @(posedge ref_clk);
    rdc(iec_pkg::OFF_STATUS, 8'h00);
  endtask
  task automatic t_event();
    int k;
    wr(iec_pkg::OFF_LIMIT, 8'h02);
    wr(iec_pkg::OFF_MODE, 8'h0c);
    P.pulses(2);
    rdc(iec_pkg::OFF_COUNT, 8'h02);
    wr(iec_pkg::OFF_MODE, 8'h0c);
    rdc(iec_pkg::OFF_COUNT, 8'h00);
    P.pulses(3);
    chk({7'h00, pin}, 8'h01);
    rdc(iec_pkg::OFF_PIN, 8'h00);
    wr(iec_pkg::OFF_MODE, 8'h1c);
    k = n_tick;
    P.pulses(3);
    chk({7'h00, pin}, 8'h01);
    chk_cnt(n_tick - k, 3);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_interval();
    t_irq_stop();
    t_event();
    final_report();
  end
endmodule // interval_event_counter_bench

`default_nettype wire
